// [verification/smf_port_rx.sv]
`timescale 1ns/1ps
// Receiver on the far side of the serial result port. It watches the port clock in
// the sample clock domain, so it never needs a second clock of its own.
module smf_port_rx (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Serial result port.
  input wire logic port_clk_i,
  input wire logic port_data_i,
  input wire logic port_frame_i,
  // Captured frame.
  output logic [91:0] word_o,
  output logic [6:0] nbits_o
);
  logic pclk_q;
  logic first_q;

  // --------------------------------------------------------------------------
  // Capture
  // --------------------------------------------------------------------------
  // Data moves on the falling port clock, so it is taken on the rising one.
  // A new frame clears the word at its first bit, not at the frame edge, since the
  // first rising port clock may come up to eight cycles into the frame, at divide by 8.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pclk_q <= 1'b0;
      first_q <= 1'b1;
      word_o <= '0;
      nbits_o <= '0;
    end else begin
      pclk_q <= port_clk_i;
      if (!port_frame_i) begin
        first_q <= 1'b1;
      end else if (port_clk_i && !pclk_q) begin
        first_q <= 1'b0;
        word_o <= {(first_q ? 91'h0 : word_o[90:0]), port_data_i};
        nbits_o <= (first_q ? 7'h00 : nbits_o) + 7'h01;
      end
    end
  end
endmodule : smf_port_rx

// [verification/tb_top.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
  logic clk_sys, rst_b, sync_pin, interleave;
  logic [1:0] chan_off;
  logic [13:0] sample_a, sample_b;
  smf_pkg::smf_reg_req_t req;
  logic [7:0] rdata;
  logic [13:0] data_a, data_b;
  smf_pkg::smf_fd_t fd_a, fd_b;
  logic fd_oe, mon_sync, div_sync, pclk, pdata, pframe;
  logic [2:0] fd_mode;
  logic [91:0] word;
  logic [6:0] nbits;
  int fails = 0;
  int checks_done = 0;

  // Sample clock, 4 ns period.
  always #2 clk_sys = ~clk_sys;

  smf_monitor u_smf_monitor (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .reg_req_i(req),
    .reg_rdata_o(rdata), .sample_a_i(sample_a), .sample_b_i(sample_b),
    .interleave_i(interleave), .chan_off_i(chan_off), .sync_pin_i(sync_pin),
    .data_a_o(data_a), .data_b_o(data_b), .fd_a_o(fd_a), .fd_b_o(fd_b), .fd_oe_o(fd_oe),
    .fd_mode_o(fd_mode), .monitor_sync_o(mon_sync), .divider_sync_o(div_sync),
    .port_clk_o(pclk), .port_data_o(pdata), .port_frame_o(pframe));
  smf_port_rx u_smf_port_rx (.clk_sys_i(clk_sys), .rst_b_i(rst_b), .port_clk_i(pclk),
    .port_data_i(pdata), .port_frame_i(pframe), .word_o(word), .nbits_o(nbits));

  // --------------------------------------------------------------------------
  // Access tasks
  // --------------------------------------------------------------------------
  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // A wait that ran out of its bound ends the run as a failure.
  task guard(input int n, input int lim);
    if (n >= lim) begin
      fails++;
      print_verdict;
    end
  endtask : guard

  task wr(input logic [8:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    req = '0;
  endtask : wr

  // Read data lands on the same edge that takes the request.
  task rdchk(input logic [8:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    req = '0;
    `CHK(rdata, e)
  endtask : rdchk

  // One align pulse, then the sync outputs are counted over the following cycles.
  task pulse(output int cm, output int cd);
    cm = 0;
    cd = 0;
    @(negedge clk_sys);
    sync_pin = 1'b1;
    repeat (2) @(negedge clk_sys);
    sync_pin = 1'b0;
    repeat (10) begin
      @(negedge clk_sys);
      cm += int'(mon_sync);
      cd += int'(div_sync);
    end
  endtask : pulse

  // Cycles between two rising edges of the port clock.
  task clk_period(output int per);
    int n;
    logic p;
    for (n = 0; n < 40; n++) begin
      p = pclk;
      @(negedge clk_sys);
      if (pclk && !p) break;
    end
    guard(n, 40);
    for (per = 1; per < 40; per++) begin
      p = pclk;
      @(negedge clk_sys);
      if (pclk && !p) break;
    end
    guard(per, 40);
  endtask : clk_period

  // --------------------------------------------------------------------------
  // Tests
  // --------------------------------------------------------------------------
  initial begin
    int cm, cd, n, per;
    logic [7:0] sv [4];
    sv = '{8'h80, 8'h81, 8'h02, 8'h03};
    clk_sys = 1'b0;
    rst_b = 1'b0;
    req = '0;
    sync_pin = 1'b0;
    interleave = 1'b0;
    chan_off = 2'b00;
    sample_a = 14'h0000;
    sample_b = 14'h0000;
    repeat (6) @(negedge clk_sys);
    rst_b = 1'b1;
    // The dc value is frozen at its reset value of zero, so the correction is exact.
    wr(smf_pkg::SMF_DC_CTL, 8'h43);
    rdchk(smf_pkg::SMF_DC_CTL, 8'h43);
    // Reset values, reserved bits, read-only and unmapped places.
    rdchk(smf_pkg::SMF_PORT_CTL, 8'h04);
    rdchk(smf_pkg::SMF_PERIOD_0, 8'h80);
    rdchk(smf_pkg::SMF_SYNC_CTL, 8'h00);
    wr(smf_pkg::SMF_COARSE, 8'hff);
    rdchk(smf_pkg::SMF_COARSE, 8'h07);
    wr(smf_pkg::SMF_DC_A_LO, 8'hff);
    rdchk(smf_pkg::SMF_DC_A_LO, 8'h00);
    rdchk(9'h101, 8'h00);
    $display("test registers done");
    // Sync gating for each output with master enable off and on, then the next-only mode.
    for (int i = 0; i < 4; i++) begin
      wr(smf_pkg::SMF_SYNC_CTL, sv[i]);
      pulse(cm, cd);
      `CHK(cm, int'(sv[i][7] & sv[i][0]))
      `CHK(cd, int'(sv[i][1] & sv[i][0]))
    end
    wr(smf_pkg::SMF_SYNC_CTL, 8'h07);
    pulse(cm, cd);
    `CHK(cd, 1)
    rdchk(smf_pkg::SMF_SYNC_CTL, 8'h05);
    pulse(cm, cd);
    `CHK(cd, 0)
    $display("test sync done");
    // Fast detect thresholds and output enable.
    sample_a = 14'h0800;
    wr(smf_pkg::SMF_COARSE, 8'h01);
    wr(smf_pkg::SMF_FUP_LO, 8'h00);
    wr(smf_pkg::SMF_FUP_HI, 8'h01);
    wr(smf_pkg::SMF_FLO_LO, 8'h10);
    wr(smf_pkg::SMF_DWELL_LO, 8'd20);
    wr(smf_pkg::SMF_FD_CTL, 8'h0a);
    repeat (4) @(negedge clk_sys);
    `CHK(fd_oe, 1'b0)
    wr(smf_pkg::SMF_FD_CTL, 8'h0b);
    repeat (4) @(negedge clk_sys);
    `CHK(fd_oe, 1'b1)
    `CHK(fd_mode, 3'h5)
    `CHK({fd_a.coarse_upper, fd_a.fine_upper_flag, fd_a.fine_lower_flag}, 3'b110)
    `CHK({fd_b.coarse_upper, fd_b.fine_upper_flag, fd_b.fine_lower_flag}, 3'b001)
    `CHK(data_a, sample_a)
    `CHK(data_b, sample_b)
    interleave = 1'b1;
    chan_off = 2'b01;
    repeat (4) @(negedge clk_sys);
    `CHK(fd_oe, 1'b1)
    `CHK(fd_a, fd_b)
    chan_off = 2'b11;
    repeat (4) @(negedge clk_sys);
    `CHK(fd_oe, 1'b0)
    interleave = 1'b0;
    chan_off = 2'b00;
    // Gain dwell: the count restarts once the level rises above the lower threshold.
    sample_b = 14'h0100;
    repeat (3) @(negedge clk_sys);
    `CHK(fd_b.increase_gain, 1'b0)
    sample_b = 14'h0000;
    for (n = 0; n < 60 && fd_b.increase_gain !== 1'b1; n++) @(negedge clk_sys);
    guard(n, 60);
    `CHK(n >= 20 && n <= 24, 1'b1)
    $display("test fast detect done");
    // Port clock divide table and sleep.
    for (int d = 0; d < 4; d++) begin
      wr(smf_pkg::SMF_PORT_CTL, 8'(d << 2));
      clk_period(per);
      `CHK(per, (d < 2) ? 2 : (2 << (d - 1)))
    end
    wr(smf_pkg::SMF_PORT_CTL, 8'h06);
    n = 0;
    repeat (20) begin
      @(negedge clk_sys);
      n += int'(pclk);
    end
    `CHK(n, 0)
    $display("test port clock done");
    // Peak frames: a short period is raised to the minimum count.
    sample_b = 14'h0040;
    wr(smf_pkg::SMF_PERIOD_0, 8'h05);
    wr(smf_pkg::SMF_PORT_CTL, 8'h25);
    wr(smf_pkg::SMF_MON_CTL, 8'h03);
    for (n = 0; n < 400 && pframe !== 1'b1; n++) @(negedge clk_sys);
    guard(n, 400);
    // Time the next frame start from this one, so the frame's own length counts too.
    for (n = 0; n < 400 && pframe !== 1'b0; n++) @(negedge clk_sys);
    guard(n, 400);
    for (per = n; per < 400 && pframe !== 1'b1; per++) @(negedge clk_sys);
    guard(per, 400);
    `CHK(per, 128)
    for (n = 0; n < 400 && pframe !== 1'b0; n++) @(negedge clk_sys);
    guard(n, 400);
    repeat (3) @(negedge clk_sys);
    `CHK(nbits, 7'd26)
    `CHK(word[25:0], {13'h0800, 13'h0040})
    rdchk(smf_pkg::SMF_RES_A_1, 8'h08);
    rdchk(smf_pkg::SMF_RES_B_0, 8'h40);
    $display("test serial port done");
    // Whole-period results: rms, mean square, complex power, threshold count.
    wr(smf_pkg::SMF_MON_CTL, 8'h01);
    repeat (300) @(negedge clk_sys);
    rdchk(smf_pkg::SMF_RES_A_1, 8'h08);
    rdchk(smf_pkg::SMF_RES_B_0, 8'h40);
    wr(smf_pkg::SMF_MON_CTL, 8'h09);
    repeat (300) @(negedge clk_sys);
    rdchk(smf_pkg::SMF_RES_A_1, 8'h80);
    rdchk(smf_pkg::SMF_RES_B_0, 8'h20);
    wr(smf_pkg::SMF_MON_CTL, 8'h81);
    repeat (300) @(negedge clk_sys);
    rdchk(smf_pkg::SMF_RES_B_1, 8'h08);
    wr(smf_pkg::SMF_MON_CTL, 8'h05);
    repeat (300) @(negedge clk_sys);
    rdchk(smf_pkg::SMF_RES_A_0, 8'h80);
    rdchk(smf_pkg::SMF_RES_B_0, 8'h00);
    // A long run at a large level has passed, yet the frozen dc value is still zero.
    rdchk(smf_pkg::SMF_DC_A_LO, 8'h00);
    rdchk(smf_pkg::SMF_DC_A_HI, 8'h00);
    $display("test monitor modes done");
    print_verdict;
  end
endmodule : tb_top

// [verilog/smf_monitor.sv]
`timescale 1ns/1ps
module smf_monitor (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // Register access.
  input wire smf_pkg::smf_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // Converter samples and channel state.
  input wire logic [13:0] sample_a_i,
  input wire logic [13:0] sample_b_i,
  input wire logic interleave_i,
  input wire logic [1:0] chan_off_i,
  input wire logic sync_pin_i,
  // Corrected data path.
  output logic [13:0] data_a_o,
  output logic [13:0] data_b_o,
  // Fast detect pins.
  output smf_pkg::smf_fd_t fd_a_o,
  output smf_pkg::smf_fd_t fd_b_o,
  output logic fd_oe_o,
  output logic [2:0] fd_mode_o,
  // Sync pulses.
  output logic monitor_sync_o,
  output logic divider_sync_o,
  // Serial result port.
  output logic port_clk_o,
  output logic port_data_o,
  output logic port_frame_o
);

  // ---------------------------------------------------------------------
  // State.
  // ---------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] sync_ctl;
    logic [3:0] fd_ctl;
    logic [2:0] coarse;
    logic [12:0] fup;
    logic [12:0] flo;
    logic [15:0] dwell;
    logic [6:0] dc_ctl;
    logic [6:0] port_ctl;
    logic [7:0] mon_ctl;
    logic [23:0] period;
    logic [2:0] sync_s;
    logic mon_sync;
    logic div_sync;
    logic [1:0][41:0] dc_acc;
    logic [1:0][13:0] dc;
    logic [1:0][13:0] data;
    logic [1:0][3:0] fd;
    logic fd_oe;
    logic [1:0][15:0] gain_cnt;
    logic [23:0] cnt;
    logic [1:0][12:0] peak;
    logic [1:0][12:0] thr;
    logic [1:0][50:0] sum;
    logic [1:0][19:0] res;
    logic [91:0] sh;
    logic [6:0] bits;
    logic busy;
    logic pclk;
    logic [1:0] div;
    logic [7:0] rdata;
  } smf_state_t;

  smf_state_t s;
  smf_state_t n;

  // ---------------------------------------------------------------------
  // Arithmetic helpers.
  // ---------------------------------------------------------------------
  function automatic logic [12:0] smf_mag(input logic [13:0] x);
    logic [13:0] a;
    begin
      a = x[13] ? 14'(-x) : x;
      smf_mag = a[13] ? 13'h1fff : a[12:0];
    end
  endfunction : smf_mag

  function automatic logic [13:0] smf_sub(input logic [13:0] x, input logic [13:0] d);
    logic signed [14:0] t;
    begin
      t = $signed({x[13], x}) - $signed({d[13], d});
      if (t > 15'sd8191) begin
        smf_sub = 14'h1fff;
      end else if (t < -15'sd8192) begin
        smf_sub = 14'h2000;
      end else begin
        smf_sub = t[13:0];
      end
    end
  endfunction : smf_sub
  function automatic logic [13:0] smf_sqrt(input logic [26:0] v);
    logic [13:0] r;
    logic [13:0] t;
    begin
      r = 14'h0;
      for (int i = 13; i >= 0; i--) begin
        t = r | 14'(1 << i);
        if (28'(t) * 28'(t) <= 28'(v)) begin
          r = t;
        end
      end
      smf_sqrt = r;
    end
  endfunction : smf_sqrt
  function automatic logic [4:0] smf_log2(input logic [23:0] v);
    logic [4:0] r;
    begin
      r = 5'h0;
      for (int i = 0; i < 24; i++) begin
        if (v[i]) begin
          r = 5'(i);
        end
      end
      smf_log2 = r;
    end
  endfunction : smf_log2

  // ---------------------------------------------------------------------
  // Combinational helpers.
  // ---------------------------------------------------------------------
  logic [1:0][13:0] smp;
  logic [1:0][13:0] mon_in;
  logic [1:0][12:0] mag;
  logic [1:0][26:0] pw;
  logic [1:0][12:0] peak_u;
  logic [1:0][12:0] thr_u;
  logic [1:0][50:0] sum_u;
  logic [1:0][19:0] mag20;
  logic [1:0] lower;
  logic signed [41:0] diff;
  logic [50:0] mean_w;
  logic [26:0] mean;
  logic [3:0] k;
  logic [23:0] eff;
  logic pulse;
  logic per_end;
  logic tick;
  logic [91:0] word;
  logic [6:0] len;
  logic [1:0] act;
  assign smp[0] = sample_a_i;
  assign smp[1] = sample_b_i;

  // Next state: registers, sync gating, dc loop, detect, monitor and port.
  always_comb begin
    n = s;
    mon_in = '0;
    mag = '0;
    pw = '0;
    peak_u = '0;
    thr_u = '0;
    sum_u = '0;
    mag20 = '0;
    lower = '0;
    diff = '0;
    mean_w = '0;
    mean = '0;
    word = '0;
    len = 7'h0;
    act = 2'b11;

    // Register writes; read data is captured on the same edge that samples the strobe.
    if (reg_req_i.wr) begin
      unique case (reg_req_i.addr)
        smf_pkg::SMF_SYNC_CTL: n.sync_ctl = reg_req_i.wdata & 8'h87;
        smf_pkg::SMF_FD_CTL: n.fd_ctl = reg_req_i.wdata[3:0];
        smf_pkg::SMF_COARSE: n.coarse = reg_req_i.wdata[2:0];
        smf_pkg::SMF_FUP_LO: n.fup[7:0] = reg_req_i.wdata;
        smf_pkg::SMF_FUP_HI: n.fup[12:8] = reg_req_i.wdata[4:0];
        smf_pkg::SMF_FLO_LO: n.flo[7:0] = reg_req_i.wdata;
        smf_pkg::SMF_FLO_HI: n.flo[12:8] = reg_req_i.wdata[4:0];
        smf_pkg::SMF_DWELL_LO: n.dwell[7:0] = reg_req_i.wdata;
        smf_pkg::SMF_DWELL_HI: n.dwell[15:8] = reg_req_i.wdata;
        smf_pkg::SMF_DC_CTL: n.dc_ctl = reg_req_i.wdata[6:0];
        smf_pkg::SMF_PORT_CTL: n.port_ctl = reg_req_i.wdata[6:0];
        smf_pkg::SMF_MON_CTL: n.mon_ctl = reg_req_i.wdata & 8'h8f;
        smf_pkg::SMF_PERIOD_0: n.period[7:0] = reg_req_i.wdata;
        smf_pkg::SMF_PERIOD_1: n.period[15:8] = reg_req_i.wdata;
        smf_pkg::SMF_PERIOD_2: n.period[23:16] = reg_req_i.wdata;
        default: ;
      endcase
    end
    if (reg_req_i.rd) begin
      unique case (reg_req_i.addr)
        smf_pkg::SMF_SYNC_CTL: n.rdata = s.sync_ctl;
        smf_pkg::SMF_FD_CTL: n.rdata = {4'h0, s.fd_ctl};
        smf_pkg::SMF_COARSE: n.rdata = {5'h0, s.coarse};
        smf_pkg::SMF_FUP_LO: n.rdata = s.fup[7:0];
        smf_pkg::SMF_FUP_HI: n.rdata = {3'h0, s.fup[12:8]};
        smf_pkg::SMF_FLO_LO: n.rdata = s.flo[7:0];
        smf_pkg::SMF_FLO_HI: n.rdata = {3'h0, s.flo[12:8]};
        smf_pkg::SMF_DWELL_LO: n.rdata = s.dwell[7:0];
        smf_pkg::SMF_DWELL_HI: n.rdata = s.dwell[15:8];
        smf_pkg::SMF_DC_CTL: n.rdata = {1'b0, s.dc_ctl};
        smf_pkg::SMF_DC_A_LO: n.rdata = s.dc[0][7:0];
        smf_pkg::SMF_DC_A_HI: n.rdata = {2'h0, s.dc[0][13:8]};
        smf_pkg::SMF_DC_B_LO: n.rdata = s.dc[1][7:0];
        smf_pkg::SMF_DC_B_HI: n.rdata = {2'h0, s.dc[1][13:8]};
        smf_pkg::SMF_PORT_CTL: n.rdata = {1'b0, s.port_ctl};
        smf_pkg::SMF_MON_CTL: n.rdata = s.mon_ctl;
        smf_pkg::SMF_PERIOD_0: n.rdata = s.period[7:0];
        smf_pkg::SMF_PERIOD_1: n.rdata = s.period[15:8];
        smf_pkg::SMF_PERIOD_2: n.rdata = s.period[23:16];
        smf_pkg::SMF_RES_A_0: n.rdata = s.res[0][7:0];
        smf_pkg::SMF_RES_A_1: n.rdata = s.res[0][15:8];
        smf_pkg::SMF_RES_A_2: n.rdata = {4'h0, s.res[0][19:16]};
        smf_pkg::SMF_RES_B_0: n.rdata = s.res[1][7:0];
        smf_pkg::SMF_RES_B_1: n.rdata = s.res[1][15:8];
        smf_pkg::SMF_RES_B_2: n.rdata = {4'h0, s.res[1][19:16]};
        default: n.rdata = 8'h00;
      endcase
    end

    // Sync pin: only the synchronised copy feeds the edge detector.
    n.sync_s = {s.sync_s[1:0], sync_pin_i};
    pulse = s.sync_s[1] & ~s.sync_s[2];
    n.mon_sync = pulse & s.sync_ctl[smf_pkg::SMF_SYNC_MASTER]
        & s.sync_ctl[smf_pkg::SMF_SYNC_MON];
    n.div_sync = pulse & s.sync_ctl[smf_pkg::SMF_SYNC_MASTER]
        & s.sync_ctl[smf_pkg::SMF_SYNC_DIV];
    // A software write in the same cycle overrides the self-clear.
    if (n.div_sync && s.sync_ctl[smf_pkg::SMF_SYNC_NEXT] && !reg_req_i.wr) begin
      n.sync_ctl[smf_pkg::SMF_SYNC_DIV] = 1'b0;
    end

    // DC loop: first-order average with shift k+14; k above 13 clamps.
    k = (s.dc_ctl[5:2] > smf_pkg::SMF_K_MAX) ? smf_pkg::SMF_K_MAX : s.dc_ctl[5:2];
    for (int c = 0; c < 2; c++) begin
      diff = $signed({smp[c], 28'h0}) - $signed(s.dc_acc[c]);
      n.dc_acc[c] = 42'($signed(s.dc_acc[c]) + (diff >>> (5'(k) + 5'he)));
      if (!s.dc_ctl[smf_pkg::SMF_DC_FREEZE]) begin
        n.dc[c] = s.dc_acc[c][41:28];
      end
      n.data[c] = s.dc_ctl[smf_pkg::SMF_DC_PATH_EN] ? smf_sub(smp[c], s.dc[c]) : smp[c];
      mon_in[c] = s.dc_ctl[smf_pkg::SMF_DC_MON_EN] ? smf_sub(smp[c], s.dc[c]) : smp[c];
      mag[c] = smf_mag(mon_in[c]);
    end

    // Threshold flags and gain dwell per channel.
    for (int c = 0; c < 2; c++) begin
      lower[c] = mag[c] < s.flo;
      n.gain_cnt[c] = lower[c] ? ((s.gain_cnt[c] == 16'hffff) ? s.gain_cnt[c]
          : 16'(s.gain_cnt[c] + 16'h1)) : 16'h0;
      n.fd[c][3] = mag[c] >= {s.coarse, 10'h0};
      n.fd[c][2] = mag[c] > s.fup;
      n.fd[c][1] = lower[c];
      n.fd[c][0] = lower[c] && (s.gain_cnt[c] >= s.dwell);
    end
    // Interleaved mode with one channel off repeats the live channel in both slots.
    if (interleave_i) begin
      act = ~chan_off_i;
      if (act == 2'b01) begin
        n.fd[1] = n.fd[0];
      end else if (act == 2'b10) begin
        n.fd[0] = n.fd[1];
      end
    end
    n.fd_oe = s.fd_ctl[smf_pkg::SMF_FD_EN] && (act != 2'b00);

    // Monitor period; programmed values under the minimum use the minimum.
    eff = (s.period < smf_pkg::SMF_PERIOD_MIN) ? smf_pkg::SMF_PERIOD_MIN : s.period;
    per_end = s.cnt >= 24'(eff - 24'h1);
    for (int c = 0; c < 2; c++) begin
      if (s.mon_ctl[smf_pkg::SMF_MON_CPLX]) begin
        pw[c] = 27'(26'(mag[0]) * 26'(mag[0])) + 27'(26'(mag[1]) * 26'(mag[1]));
      end else begin
        pw[c] = 27'(26'(mag[c]) * 26'(mag[c]));
      end
      peak_u[c] = (mag[c] > s.peak[c]) ? mag[c] : s.peak[c];
      thr_u[c] = (mag[c] > s.fup && s.thr[c] != 13'h1fff) ? 13'(s.thr[c] + 13'h1) : s.thr[c];
      sum_u[c] = 51'(s.sum[c] + 51'(pw[c]));
      mean_w = sum_u[c] >> smf_log2(eff);
      mean = (mean_w > 51'h7ffffff) ? 27'h7ffffff : mean_w[26:0];
      mag20[c] = s.mon_ctl[smf_pkg::SMF_MON_MS] ? mean[26:7]
          : {6'h0, smf_sqrt(mean)};
    end
    if (!s.mon_ctl[smf_pkg::SMF_MON_EN] || s.mon_sync) begin
      n.cnt = 24'h0;
      n.peak = '0;
      n.thr = '0;
      n.sum = '0;
    end else if (per_end) begin
      n.cnt = 24'h0;
      n.peak = '0;
      n.thr = '0;
      n.sum = '0;
      for (int c = 0; c < 2; c++) begin
        unique case (s.mon_ctl[2:1])
          2'b00: n.res[c] = mag20[c];
          2'b01: n.res[c] = {7'h0, peak_u[c]};
          default: n.res[c] = {7'h0, thr_u[c]};
        endcase
        if (s.port_ctl[smf_pkg::SMF_PORT_MAG_EN]) begin
          word = {word[71:0], mag20[c]};
          len = 7'(len + 7'h14);
        end
        if (s.port_ctl[smf_pkg::SMF_PORT_PEAK_EN]) begin
          word = {word[78:0], peak_u[c]};
          len = 7'(len + 7'h0d);
        end
        if (s.port_ctl[smf_pkg::SMF_PORT_THR_EN]) begin
          word = {word[78:0], thr_u[c]};
          len = 7'(len + 7'h0d);
        end
      end
    end else begin
      n.cnt = 24'(s.cnt + 24'h1);
      n.peak = peak_u;
      n.thr = thr_u;
      n.sum = sum_u;
    end

    // Port clock: half period of 1, 2 or 4 cycles gives divide by 2, 4, 8.
    n.div = 2'(s.div + 2'h1);
    unique case (s.port_ctl[3:2])
      2'b10: tick = s.div[0];
      2'b11: tick = &s.div;
      default: tick = 1'b1;
    endcase
    if (tick) begin
      if (s.busy || !s.port_ctl[smf_pkg::SMF_PORT_SLEEP]) begin
        n.pclk = ~s.pclk;
      end else begin
        n.pclk = 1'b0;
      end
      // Data moves on the falling edge so the receiver samples on rising.
      if (s.pclk && s.busy) begin
        n.sh = {s.sh[90:0], 1'b0};
        n.bits = 7'(s.bits - 7'h1);
        n.busy = s.bits != 7'h1;
      end
    end
    // A frame still shifting when a new period ends drops the new results.
    if (per_end && s.mon_ctl[smf_pkg::SMF_MON_EN] && !s.mon_sync && !s.busy
        && s.port_ctl[smf_pkg::SMF_PORT_EN] && len != 7'h0) begin
      n.sh = word << (smf_pkg::SMF_FRAME_BITS - len);
      n.bits = len;
      n.busy = 1'b1;
    end
  end

  // State register.
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s <= '0;
      s.port_ctl <= smf_pkg::SMF_PORT_CTL_RST;
      s.period <= smf_pkg::SMF_PERIOD_RST;
    end else begin
      s <= n;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs, all straight from state.
  // ---------------------------------------------------------------------
  assign reg_rdata_o = s.rdata;
  assign data_a_o = s.data[0];
  assign data_b_o = s.data[1];
  assign fd_a_o = s.fd[0];
  assign fd_b_o = s.fd[1];
  assign fd_oe_o = s.fd_oe;
  assign fd_mode_o = s.fd_ctl[3:1];
  assign monitor_sync_o = s.mon_sync;
  assign divider_sync_o = s.div_sync;
  assign port_clk_o = s.pclk;
  assign port_data_o = s.sh[91];
  assign port_frame_o = s.busy;

  // ---------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------
  default clocking smf_cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  a_mon_sync_gate: assert property (monitor_sync_o |-> $past(s.sync_ctl[7] && s.sync_ctl[0]))
    else $error("Monitor sync passed without both enables.");
  a_div_sync_gate: assert property (divider_sync_o |-> $past(s.sync_ctl[1] && s.sync_ctl[0]))
    else $error("Divider sync passed without both enables.");
  a_next_only_clr: assert property ((divider_sync_o && $past(s.sync_ctl[2])
      && !$past(reg_req_i.wr)) |-> !s.sync_ctl[1])
    else $error("Divider sync enable did not clear after next-only sync.");
  a_master_blocks: assert property (!$past(s.sync_ctl[0]) |-> !monitor_sync_o && !divider_sync_o)
    else $error("Sync passed with master enable low.");
  a_fd_hiz: assert property (!$past(s.fd_ctl[0]) |-> !fd_oe_o)
    else $error("Fast detect driven while disabled.");
  a_fine_upper: assert property ($past(rst_b_i && !interleave_i) |->
      fd_a_o.fine_upper_flag == ($past(mag[0]) > $past(s.fup)))
    else $error("Fine upper flag does not match compare.");
  a_gain_dwell: assert property (fd_a_o.increase_gain && !$past(interleave_i)
      |-> $past(s.gain_cnt[0]) >= $past(s.dwell))
    else $error("Increase gain before dwell count.");
  a_port_sleep: assert property ((s.port_ctl[1] && !s.busy)[*5] |-> !port_clk_o)
    else $error("Port clock running while asleep and idle.");
  a_port_start: assert property ($rose(port_frame_o) |-> $past(s.port_ctl[0]))
    else $error("Frame started with port disabled.");
endmodule : smf_monitor

// [verilog/smf_pkg.sv]
package smf_pkg;

  // ---------------------------------------------------------------------
  // Register offsets.
  // ---------------------------------------------------------------------
  localparam logic [8:0] SMF_SYNC_CTL = 9'h100;
  localparam logic [8:0] SMF_FD_CTL = 9'h104;
  localparam logic [8:0] SMF_COARSE = 9'h105;
  localparam logic [8:0] SMF_FUP_LO = 9'h106;
  localparam logic [8:0] SMF_FUP_HI = 9'h107;
  localparam logic [8:0] SMF_FLO_LO = 9'h108;
  localparam logic [8:0] SMF_FLO_HI = 9'h109;
  localparam logic [8:0] SMF_DWELL_LO = 9'h10a;
  localparam logic [8:0] SMF_DWELL_HI = 9'h10b;
  localparam logic [8:0] SMF_DC_CTL = 9'h10c;
  localparam logic [8:0] SMF_DC_A_LO = 9'h10d;
  localparam logic [8:0] SMF_DC_A_HI = 9'h10e;
  localparam logic [8:0] SMF_DC_B_LO = 9'h10f;
  localparam logic [8:0] SMF_DC_B_HI = 9'h110;
  localparam logic [8:0] SMF_PORT_CTL = 9'h111;
  localparam logic [8:0] SMF_MON_CTL = 9'h112;
  localparam logic [8:0] SMF_PERIOD_0 = 9'h113;
  localparam logic [8:0] SMF_PERIOD_1 = 9'h114;
  localparam logic [8:0] SMF_PERIOD_2 = 9'h115;
  localparam logic [8:0] SMF_RES_A_0 = 9'h116;
  localparam logic [8:0] SMF_RES_A_1 = 9'h117;
  localparam logic [8:0] SMF_RES_A_2 = 9'h118;
  localparam logic [8:0] SMF_RES_B_0 = 9'h119;
  localparam logic [8:0] SMF_RES_B_1 = 9'h11a;
  localparam logic [8:0] SMF_RES_B_2 = 9'h11b;

  // ---------------------------------------------------------------------
  // Field positions.
  // ---------------------------------------------------------------------
  localparam int SMF_SYNC_MASTER = 0;
  localparam int SMF_SYNC_DIV = 1;
  localparam int SMF_SYNC_NEXT = 2;
  localparam int SMF_SYNC_MON = 7;
  localparam int SMF_FD_EN = 0;
  localparam int SMF_DC_MON_EN = 0;
  localparam int SMF_DC_PATH_EN = 1;
  localparam int SMF_DC_FREEZE = 6;
  localparam int SMF_PORT_EN = 0;
  localparam int SMF_PORT_SLEEP = 1;
  localparam int SMF_PORT_THR_EN = 4;
  localparam int SMF_PORT_PEAK_EN = 5;
  localparam int SMF_PORT_MAG_EN = 6;
  localparam int SMF_MON_EN = 0;
  localparam int SMF_MON_MS = 3;
  localparam int SMF_MON_CPLX = 7;

  // ---------------------------------------------------------------------
  // Reset values and counts.
  // ---------------------------------------------------------------------
  localparam logic [6:0] SMF_PORT_CTL_RST = 7'h04;
  localparam logic [23:0] SMF_PERIOD_RST = 24'h000080;
  localparam logic [23:0] SMF_PERIOD_MIN = 24'h000080;
  localparam logic [3:0] SMF_K_MAX = 4'hd;
  localparam logic [5:0] SMF_DC_FRAC = 6'h1c;
  localparam logic [6:0] SMF_FRAME_BITS = 7'h5c;

  // Register access request from the serial control port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [8:0] addr;
    logic [7:0] wdata;
  } smf_reg_req_t;

  // Fast detect indications of one channel.
  typedef struct packed {
    logic coarse_upper;
    logic fine_upper_flag;
    logic fine_lower_flag;
    logic increase_gain;
  } smf_fd_t;

endpackage : smf_pkg
